// ---- src/can_asc_pkg.sv ----
// Constants, field layouts and carrier types for the serial-window and sync block
package can_asc_pkg;
   localparam logic [11:0] ADDR_CTRL = 12'h018;
   localparam logic [11:0] ADDR_SCHED = 12'h100;
   localparam logic [11:0] ADDR_STAT = 12'h104;
   localparam logic [11:0] ADDR_TARGET = 12'h108;
   localparam logic [11:0] ADDR_REFOFS = 12'h10c;
   localparam int CTRL_INIT = 0;
   localparam int CTRL_CCE = 1;
   localparam int CTRL_RPM = 2;
   localparam logic [2:0] CTRL_RESET = 3'h1;
   localparam int SCHED_OM_LSB = 0;
   localparam int SCHED_ESYNC = 4;
   localparam int STAT_LOCKED = 0;
   localparam int STAT_LOST = 1;
   localparam int STAT_MS_LSB = 4;
   localparam logic [1:0] OM_LEVEL1 = 2'h1;
   localparam logic [1:0] OM_LEVEL2 = 2'h2;
   localparam logic [1:0] MS_CURRENT = 2'h3;
   localparam logic [1:0] SEL_OFF = 2'h0;
   localparam logic [1:0] SEL_RECV = 2'h1;
   localparam logic [15:0] LOCK_WINDOW_NTU = 16'h0009;
   localparam logic [3:0] IDLE_BITS = 4'hb;

   typedef struct packed {
      logic valid;
      logic [1:0] serial_sel;
   } trigger_t;

   typedef enum logic {guard_open, guard_wait} guard_t;

   typedef struct packed {
      logic [2:0] ctrl;
      logic [1:0] op_mode;
      logic esync;
      logic locked;
      logic lost;
      logic [15:0] target;
      logic [15:0] ref_ofs;
      logic ref_vld;
      logic owner;
      logic txsel;
      logic [1:0] ms_prev;
      logic evt_s1;
      logic evt_s2;
      logic evt_s3;
      logic armed;
      guard_t guard;
      logic [3:0] idle_cnt;
      logic tx_permit;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_t;
endpackage

// ---- src/can_asc_sync.sv ----
// Serial-window bus multiplexer control and external schedule phase lock
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
// Overview of operation
// - Serial windows only in level 1 or 2
// - Each trigger element carries its window select
// - Select 00 drives both selects low
// - Select 01 makes serial unit receiver
// - Select 10 makes serial unit transmitter
// - Software sets mode in init; window end clears
// - Scheduled 10/11 trigger sets restricted mode
// - Scheduled 00 trigger clears restricted mode
// - Restricted mode: no error frames, counters frozen
// - In restricted mode, after error wait 11 recessive bits
// - Selects low unless schedule synchronized
// - External sync only as current time master
// - Event rising edge compares cycle time
// - Enabling sync sets phase lock
// - Difference above 9 loses lock, flags
// - Master takeover loses lock, flags
// - Small difference while locked becomes reference trigger offset
// - One compare per basic cycle
module can_asc_sync (
   input wire logic pclk, // 40 MHz clock
   input wire logic presetn, // Async reset, low
   input wire logic [11:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire can_asc_pkg::trigger_t trig, // Trigger element activation
   input wire logic sched_synced, // In schedule or in gap
   input wire logic [1:0] master_state, // Time master state
   input wire logic [15:0] cycle_time, // Cycle time in NETWORK_TIME_UNIT
   input wire logic basic_cycle_start, // Pulse at basic cycle start
   input wire logic event_in, // External event pin
   input wire logic proto_event, // Engine saw error or overload
   input wire logic bit_tick, // One pulse per bit time
   input wire logic rx_bit, // Sampled bus level, 1 recessive
   output logic bus_owner_sel, // Serial unit owns transceiver
   output logic serial_tx_sel, // Serial unit transmits
   output logic restricted_protocol_mode, // Engine restricted mode
   output logic tx_permit, // Engine may start a frame
   output logic [15:0] ref_trigger_offset, // Offset for next reference
   output logic ref_offset_valid // Pulse, new offset
);
   can_asc_pkg::state_t q, d;
   logic win_ok;
   logic is_master;
   logic edge_seen;
   logic compare;
   logic [15:0] diff;
   logic [15:0] mag;
   logic setup_acc;
   logic done_acc;

   function automatic logic [15:0] abs16(input logic [15:0] v);
      return v[15] ? 16'(-v) : v;
   endfunction

   assign win_ok = (q.op_mode == can_asc_pkg::OM_LEVEL1 || q.op_mode == can_asc_pkg::OM_LEVEL2)
      && sched_synced && !q.ctrl[can_asc_pkg::CTRL_INIT];
   assign is_master = master_state == can_asc_pkg::MS_CURRENT;
   assign edge_seen = q.evt_s2 && !q.evt_s3;
   assign compare = edge_seen && q.armed && q.esync && is_master;
   assign diff = 16'(cycle_time - q.target);
   assign mag = abs16(diff);
   assign setup_acc = psel && penable && !q.pready;
   assign done_acc = psel && penable && q.pready;

   always_comb begin
      d = q;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.ref_vld = 1'b0;
      // Read data is captured one cycle ahead so it comes from a flop
      if (setup_acc) begin
         d.pready = 1'b1;
         d.prdata = 32'h0;
         unique case (paddr)
            can_asc_pkg::ADDR_CTRL: d.prdata[2:0] = q.ctrl;
            can_asc_pkg::ADDR_SCHED: begin
               d.prdata[can_asc_pkg::SCHED_OM_LSB +: 2] = q.op_mode;
               d.prdata[can_asc_pkg::SCHED_ESYNC] = q.esync;
            end
            can_asc_pkg::ADDR_STAT: begin
               d.prdata[can_asc_pkg::STAT_LOCKED] = q.locked;
               d.prdata[can_asc_pkg::STAT_LOST] = q.lost;
               d.prdata[can_asc_pkg::STAT_MS_LSB +: 2] = master_state;
            end
            can_asc_pkg::ADDR_TARGET: d.prdata[15:0] = q.target;
            can_asc_pkg::ADDR_REFOFS: d.prdata[15:0] = q.ref_ofs;
            default: d.pslverr = 1'b1;
         endcase
      end
      // Writes land on the completing edge; hardware events below win
      if (done_acc && pwrite) begin
         unique case (paddr)
            can_asc_pkg::ADDR_CTRL: begin
               d.ctrl[can_asc_pkg::CTRL_INIT] = pwdata[can_asc_pkg::CTRL_INIT];
               d.ctrl[can_asc_pkg::CTRL_CCE] = pwdata[can_asc_pkg::CTRL_CCE];
               // Mode bit is software-owned only during init
               if (q.ctrl[can_asc_pkg::CTRL_INIT]) begin
                  d.ctrl[can_asc_pkg::CTRL_RPM] = pwdata[can_asc_pkg::CTRL_RPM];
               end
            end
            can_asc_pkg::ADDR_SCHED: begin
               d.op_mode = pwdata[can_asc_pkg::SCHED_OM_LSB +: 2];
               d.esync = pwdata[can_asc_pkg::SCHED_ESYNC];
               if (pwdata[can_asc_pkg::SCHED_ESYNC] && !q.esync) begin
                  d.locked = 1'b1;
               end
            end
            can_asc_pkg::ADDR_STAT: begin
               if (pwdata[can_asc_pkg::STAT_LOST]) begin
                  d.lost = 1'b0;
               end
            end
            can_asc_pkg::ADDR_TARGET: d.target = pwdata[15:0];
            default: ;
         endcase
      end
      // Window selection, taken per trigger element
      if (!win_ok) begin
         d.owner = 1'b0;
         d.txsel = 1'b0;
      end else if (trig.valid) begin
         d.owner = trig.serial_sel != can_asc_pkg::SEL_OFF;
         d.txsel = trig.serial_sel[1];
         if (trig.serial_sel[1]) begin
            d.ctrl[can_asc_pkg::CTRL_RPM] = 1'b1;
         end else if (trig.serial_sel == can_asc_pkg::SEL_OFF) begin
            d.ctrl[can_asc_pkg::CTRL_RPM] = 1'b0;
         end
      end
      // Transmit guard: in restricted mode, bus idle must be seen before a frame may start.
      // Entering restricted mode counts as an error condition, so the
      // engine never starts a frame into a serial window still in use.
      // The count restarts on any dominant bit, never only at the edge.
      if (!q.ctrl[can_asc_pkg::CTRL_RPM]) begin
         d.guard = can_asc_pkg::guard_open;
         d.tx_permit = 1'b1;
         d.idle_cnt = 4'h0;
         if (d.ctrl[can_asc_pkg::CTRL_RPM]) begin
            d.guard = can_asc_pkg::guard_wait;
            d.tx_permit = 1'b0;
         end
      end else if (proto_event) begin
         d.guard = can_asc_pkg::guard_wait;
         d.tx_permit = 1'b0;
         d.idle_cnt = 4'h0;
      end else begin
         unique case (q.guard)
            can_asc_pkg::guard_open: d.tx_permit = 1'b1;
            can_asc_pkg::guard_wait: begin
               if (bit_tick) begin
                  if (!rx_bit) begin
                     d.idle_cnt = 4'h0;
                  end else if (q.idle_cnt == can_asc_pkg::IDLE_BITS - 4'h1) begin
                     d.guard = can_asc_pkg::guard_open;
                     d.tx_permit = 1'b1;
                     d.idle_cnt = 4'h0;
                  end else begin
                     d.idle_cnt = q.idle_cnt + 4'h1;
                  end
               end
            end
         endcase
      end
      // Event input: two-flop synchroniser, then an edge stage.
      // Only the second stage feeds the edge logic; the first may be
      // metastable and must not fan out.
      d.evt_s1 = event_in;
      d.evt_s2 = q.evt_s1;
      d.evt_s3 = q.evt_s2;
      if (edge_seen && q.armed) begin
         d.armed = 1'b0;
      end
      if (basic_cycle_start) begin
         d.armed = 1'b1;
      end
      if (compare) begin
         if (mag > can_asc_pkg::LOCK_WINDOW_NTU) begin
            d.locked = 1'b0;
            d.lost = 1'b1;
         end else if (q.locked) begin
            d.ref_ofs = diff;
            d.ref_vld = 1'b1;
         end
      end
      // Leaving current master means another node has taken over
      d.ms_prev = master_state;
      if (q.ms_prev == can_asc_pkg::MS_CURRENT && !is_master) begin
         d.locked = 1'b0;
         d.lost = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ctrl <= can_asc_pkg::CTRL_RESET;
         q.tx_permit <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign bus_owner_sel = q.owner;
   assign serial_tx_sel = q.txsel;
   // Engine suppresses error frames and freezes both counters on this
   assign restricted_protocol_mode = q.ctrl[can_asc_pkg::CTRL_RPM];
   assign tx_permit = q.tx_permit;
   assign ref_trigger_offset = q.ref_ofs;
   assign ref_offset_valid = q.ref_vld;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_level_gate: assert property (!win_ok |=> !bus_owner_sel && !serial_tx_sel)
      else $error("select high outside synchronized level 1/2");
   a_sel_off: assert property (win_ok && trig.valid && trig.serial_sel == 2'h0
      |=> !bus_owner_sel && !serial_tx_sel)
      else $error("select 00 left serial unit connected");
   a_sel_recv: assert property (win_ok && trig.valid && trig.serial_sel == 2'h1
      |=> bus_owner_sel && !serial_tx_sel)
      else $error("select 01 not receiver");
   a_sel_xmit: assert property (win_ok && trig.valid && trig.serial_sel == 2'h2
      |=> bus_owner_sel && serial_tx_sel)
      else $error("select 10 not transmitter");
   a_mode_set: assert property (win_ok && trig.valid && trig.serial_sel[1]
      |=> restricted_protocol_mode)
      else $error("restricted mode not set at window start");
   a_mode_clear: assert property (win_ok && trig.valid && trig.serial_sel == 2'h0
      |=> !restricted_protocol_mode)
      else $error("restricted mode not cleared");
   a_idle_guard: assert property (restricted_protocol_mode && proto_event
      |=> !tx_permit [*2])
      else $error("transmit allowed before bus idle");
   a_lock_on_enable: assert property (done_acc && pwrite && paddr == 12'h100 && pwdata[4]
      && !q.esync |=> q.locked)
      else $error("lock not set on sync enable");
   a_big_diff: assert property (compare && mag > 16'h0009 |=> !q.locked && q.lost)
      else $error("large phase error did not drop lock");
   a_master_loss: assert property (master_state == 2'h3 ##1 master_state != 2'h3
      |=> !q.locked && q.lost)
      else $error("master takeover did not drop lock");
   a_ref_offset: assert property (compare && mag <= 16'h0009 && q.locked
      |=> ref_offset_valid && ref_trigger_offset == $past(diff))
      else $error("offset not applied");
   a_one_compare: assert property (edge_seen && !q.armed |=> !ref_offset_valid)
      else $error("second edge in cycle compared");

   // Register bus timing and answers
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_ready_access: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_err_zero: assert property (pslverr |-> prdata == 32'h0)
      else $error("unmapped read returned data");
   a_read_ctrl: assert property (setup_acc && paddr == can_asc_pkg::ADDR_CTRL
      |=> prdata == {29'h0, $past(q.ctrl)})
      else $error("control read data wrong");
   a_write_target: assert property (done_acc && pwrite && paddr == can_asc_pkg::ADDR_TARGET
      |=> q.target == $past(pwdata[15:0]))
      else $error("target phase write lost");
   a_sched_write: assert property (done_acc && pwrite && paddr == can_asc_pkg::ADDR_SCHED
      |=> q.esync == $past(pwdata[4]))
      else $error("sync enable write lost");

   // Restricted mode ownership
   a_ctrl_locked: assert property (done_acc && pwrite && paddr == can_asc_pkg::ADDR_CTRL
      && !q.ctrl[0] && !(win_ok && trig.valid) |=> $stable(restricted_protocol_mode))
      else $error("mode bit written outside init");
   a_mode_hold: assert property (win_ok && trig.valid && trig.serial_sel == 2'h1
      |=> $stable(restricted_protocol_mode))
      else $error("receive window changed mode bit");
   a_sel_order: assert property (serial_tx_sel |-> bus_owner_sel)
      else $error("transmit select without ownership");

   // Transmit guard
   a_guard_entry: assert property (!restricted_protocol_mode ##1 restricted_protocol_mode
      |-> !tx_permit)
      else $error("frame allowed on mode entry");
   a_wait_blocks: assert property (q.guard == can_asc_pkg::guard_wait |-> !tx_permit)
      else $error("frame allowed while waiting idle");
   a_open_permits: assert property (q.guard == can_asc_pkg::guard_open |-> tx_permit)
      else $error("frame refused with guard open");
   a_idle_range: assert property (q.guard == can_asc_pkg::guard_wait
      |-> q.idle_cnt < can_asc_pkg::IDLE_BITS)
      else $error("idle count out of range");

   // Event arming and phase lock
   a_arm_set: assert property (basic_cycle_start |=> q.armed)
      else $error("edge detection not armed");
   a_arm_clear: assert property (edge_seen && q.armed && !basic_cycle_start
      |=> !q.armed)
      else $error("edge detection not disarmed");
   a_slave_quiet: assert property (edge_seen && q.armed && !is_master
      |=> !ref_offset_valid)
      else $error("compare while not time master");
   a_valid_pulse: assert property (ref_offset_valid |=> !ref_offset_valid)
      else $error("offset valid held too long");
   a_ofs_hold: assert property (!compare |=> $stable(ref_trigger_offset))
      else $error("offset changed without compare");
   a_lock_kept: assert property (compare && mag <= 16'h0009 && q.locked
      && !(q.ms_prev == 2'h3 && !is_master) |=> q.locked)
      else $error("lock dropped on small difference");
   a_lost_sticky: assert property (q.lost && !(done_acc && pwrite
      && paddr == can_asc_pkg::ADDR_STAT && pwdata[1]) |=> q.lost)
      else $error("lost flag cleared without write");
   a_unlock_stays: assert property (!q.locked && !(done_acc && pwrite
      && paddr == can_asc_pkg::ADDR_SCHED) |=> !q.locked)
      else $error("lock set without sync enable");

   // Main scenarios reached

   c_xmit_window: cover property (win_ok && trig.valid && trig.serial_sel == 2'h2);
   c_lock_kept: cover property (compare && mag <= 16'h0009 && q.locked);
   c_lock_lost: cover property (compare && mag > 16'h0009);
   c_idle_reopen: cover property (q.guard == can_asc_pkg::guard_wait ##1 tx_permit);
   c_master_takeover: cover property (q.ms_prev == 2'h3 && !is_master && q.locked);
endmodule

// ---- tb/can_mux_model.sv ----
// Behavioural model of the transceiver multiplexer and serial unit
`timescale 1ns/100ps
module can_mux_model (
   input wire logic bus_owner_sel, // Serial unit owns transceiver
   input wire logic serial_tx_sel, // Serial unit transmits
   input wire logic node_bit, // Level from the other nodes
   input wire logic serial_bit, // Level the serial unit sends
   output logic rx_bit // Bus level, 1 recessive
);
   // Wired-AND bus; only this node's serial unit may transmit in its window
   assign rx_bit = node_bit & ((bus_owner_sel & serial_tx_sel) ? serial_bit : 1'b1);
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the serial-window and phase-lock block
`timescale 1ns/100ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, m;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   can_asc_pkg::trigger_t trig;
   logic sched_synced, basic_cycle_start, event_in, proto_event, bit_tick, rx_bit;
   logic bus_owner_sel, serial_tx_sel, restricted_protocol_mode, tx_permit;
   logic ref_offset_valid, node_bit, serial_bit;
   logic [1:0] master_state, s;
   logic [2:0] w;
   logic [15:0] cycle_time, ref_trigger_offset;
   int failures, compares, seed, vcnt, i, r;
   can_asc_sync u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .trig, .sched_synced, .master_state, .cycle_time,
      .basic_cycle_start, .event_in, .proto_event, .bit_tick, .rx_bit, .bus_owner_sel,
      .serial_tx_sel, .restricted_protocol_mode, .tx_permit, .ref_trigger_offset,
      .ref_offset_valid);
   can_mux_model u_mux (.bus_owner_sel, .serial_tx_sel, .node_bit, .serial_bit, .rx_bit);
   initial begin
      pclk = 0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) if (ref_offset_valid === 1'b1) vcnt++;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
      bit done = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1;
      // Hold the request until pready is seen high at a rising edge
      for (int n = 0; n < 20 && !done; n++) begin
         @(posedge pclk);
         done = (pready === 1'b1);
         rd = prdata;
         er = pslverr;
      end
      psel <= 0;
      penable <= 0;
      if (!done) begin
         failures++;
         tally_and_finish();
      end
   endtask
   task automatic fire(input logic [1:0] sel);
      @(posedge pclk);
      trig <= '{1'b1, sel};
      @(posedge pclk);
      trig <= '0;
      @(negedge pclk);
   endtask
   // Expected {owner, transmit, mode} after a trigger in an open window
   function automatic logic [2:0] exp_win(input logic [1:0] sel, input logic md);
      return {sel != 2'h0, sel[1], sel[1] | ((sel != 2'h0) & md)};
   endfunction
   task automatic bits(input int n, input logic v);
      repeat (n) begin
         @(posedge pclk);
         bit_tick <= 1;
         node_bit <= v;
         serial_bit <= v;
         @(posedge pclk);
         bit_tick <= 0;
      end
      @(negedge pclk);
   endtask
   task automatic bcs;
      @(posedge pclk);
      basic_cycle_start <= 1;
      @(posedge pclk);
      basic_cycle_start <= 0;
   endtask
   // Event edge with the cycle time offset from the 0x400 target
   task automatic evt(input logic [15:0] df);
      @(posedge pclk);
      cycle_time <= 16'h0400 + df;
      event_in <= 1;
      repeat (6) @(posedge pclk);
      event_in <= 0;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask
   initial begin
      seed = 48571;
      {failures, compares, vcnt} = '0;
      {psel, penable, pwrite, paddr, pwdata, trig} = '0;
      {sched_synced, basic_cycle_start, event_in, proto_event, bit_tick} = '0;
      {master_state, cycle_time, node_bit, serial_bit, presetn} = {2'h3, 16'h0, 3'h6};
      repeat (4) @(posedge pclk);
      presetn <= 1;
      @(negedge pclk);
      chk(32'({bus_owner_sel, serial_tx_sel, restricted_protocol_mode, tx_permit}), 1);
      apb(0, can_asc_pkg::ADDR_CTRL, 0);
      chk(rd, 32'h1);
      apb(0, 12'h200, 0);
      chk({er, rd[30:0]}, 32'h80000000);
      apb(1, can_asc_pkg::ADDR_CTRL, 32'h5);
      apb(1, can_asc_pkg::ADDR_CTRL, 32'h4);
      apb(0, can_asc_pkg::ADDR_CTRL, 0);
      chk({rd[30:0], restricted_protocol_mode}, 32'h9);
      sched_synced <= 1;
      apb(1, can_asc_pkg::ADDR_SCHED, 0);
      fire(2'h2);
      chk(32'({bus_owner_sel, serial_tx_sel}), 0);
      apb(1, can_asc_pkg::ADDR_SCHED, 32'h1);
      m = 1;
      for (i = 0; i < 24; i++) begin
         if (i == 12) apb(1, can_asc_pkg::ADDR_SCHED, 32'h2);
         s = 2'($random(seed));
         fire(s);
         w = exp_win(s, m);
         chk(32'({bus_owner_sel, serial_tx_sel, restricted_protocol_mode}), 32'(w));
         m = w[0];
      end
      fire(2'h2);
      @(posedge pclk);
      sched_synced <= 0;
      repeat (2) @(negedge pclk);
      chk(32'({bus_owner_sel, serial_tx_sel}), 0);
      sched_synced <= 1;
      fire(2'h0);
      bits(11, 1);
      chk(32'(tx_permit), 1);
      fire(2'h2);
      chk(32'(tx_permit), 0);
      bits(10, 1);
      bits(1, 0);
      bits(10, 1);
      chk(32'(tx_permit), 0);
      bits(1, 1);
      chk(32'(tx_permit), 1);
      @(posedge pclk);
      proto_event <= 1;
      @(posedge pclk);
      proto_event <= 0;
      @(negedge pclk);
      chk(32'(tx_permit), 0);
      apb(1, can_asc_pkg::ADDR_TARGET, 32'h400); // phases aligned before enable
      apb(1, can_asc_pkg::ADDR_SCHED, 32'h11);
      apb(0, can_asc_pkg::ADDR_STAT, 0);
      chk(rd & 32'h33, 32'h31);
      bcs();
      evt(16'h5);
      chk({ref_trigger_offset, 16'(vcnt)}, 32'h00050001);
      evt(16'h14);
      apb(0, can_asc_pkg::ADDR_STAT, 0);
      chk({rd[15:0], 16'(vcnt)}, 32'h00310001);
      for (i = 0; i < 3; i++) begin
         r = $random(seed) % 10;
         bcs();
         evt(16'(r));
         chk({ref_trigger_offset, 16'(vcnt)}, {16'(r), 16'(i + 2)});
      end
      bcs();
      evt(16'hfff7);
      chk(32'(ref_trigger_offset), 32'hfff7);
      bcs();
      evt(16'ha);
      apb(0, can_asc_pkg::ADDR_STAT, 0);
      chk(rd & 32'h3, 32'h2);
      apb(1, can_asc_pkg::ADDR_STAT, 32'h2);
      apb(1, can_asc_pkg::ADDR_SCHED, 32'h1);
      apb(1, can_asc_pkg::ADDR_SCHED, 32'h11);
      apb(0, can_asc_pkg::ADDR_STAT, 0);
      chk(rd & 32'h33, 32'h31);
      master_state <= 2'h1;
      apb(0, can_asc_pkg::ADDR_STAT, 0);
      chk(rd & 32'h33, 32'h12);
      apb(1, can_asc_pkg::ADDR_STAT, 32'h2);
      bcs();
      evt(16'h14);
      apb(0, can_asc_pkg::ADDR_STAT, 0);
      chk({rd[1], 31'(vcnt)}, 32'h5);
      tally_and_finish();
   end
endmodule
